// ==== csa_params.svh ====
// Function
// - Each cell built from four 2-input tables.
// - Two tables give sums for carry one, zero.
// - Two tables give carries for both chains.
// - Cluster carry-in selects chain for all cells.
// - Selected chain level picks precomputed sum output.
// - Adder output is first plus second plus carry.
// - Each chain's carry-in selects its own carry-out.
// - Cell offers registered and unregistered output together.
// - Register has enable, count, direction, clear, load.
// - Count enable and direction come from data inputs.
// - Clear and load act on all cluster registers.
// - Two cluster enables besides each cell's own enable.
// - Packing unavailable once a cell uses carry-in.
`ifndef CSA_PARAMS_SVH
`define CSA_PARAMS_SVH

// ==========================================================================
// Cluster geometry
// ==========================================================================
`define CSA_N          10
`define CSA_DW         32
`define CSA_AW         8

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define CSA_ADDR_OPA   8'h00
`define CSA_ADDR_OPB   8'h04
`define CSA_ADDR_CTRL  8'h08
`define CSA_ADDR_CELCE 8'h0c
`define CSA_ADDR_CESEL 8'h10
`define CSA_ADDR_LDVAL 8'h14
`define CSA_ADDR_CMD   8'h18
`define CSA_ADDR_STAT  8'h1c
`define CSA_ADDR_QOUT  8'h20

// ==========================================================================
// Control and command fields
// ==========================================================================
`define CSA_CTRL_W     9
`define CSA_CTRL_RST   9'h000
`define CSA_B_CIN      0
`define CSA_B_MODE_LO  1
`define CSA_B_MODE_HI  2
`define CSA_B_UP       3
`define CSA_B_CNTEN    4
`define CSA_B_CE0      5
`define CSA_B_CE1      6
`define CSA_B_PACK     7
`define CSA_B_SPARE    8
`define CSA_B_CLR      0
`define CSA_B_LD       1
`define CSA_CELL_RST   10'h000
`define CSA_CELCE_RST  10'h3ff
`define CSA_STAT_PAD   18

`endif

// ==== csa_pkg.sv ====
package csa_pkg;
  // Operating modes of the cluster; value three is plain normal mode.
  typedef enum logic [1:0] {
    CSA_MODE_ADD,
    CSA_MODE_ACC,
    CSA_MODE_CNT,
    CSA_MODE_NORM
  } csa_mode_e;
endpackage

// ==== csa_cluster.sv ====
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "csa_params.svh"

module csa_cluster
  import csa_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic                 i_hready,
  input  wire logic [`CSA_DW-1:0]   i_hwdata,
  output logic      [`CSA_DW-1:0]   o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp
);

  // ========================================================================
  // Reset release
  // ========================================================================
  logic rst_meta_q;
  logic rst_n_q;

  // Release is delayed two edges so every flop leaves reset in one cycle.
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ========================================================================
  // Bus slave
  // ========================================================================
  logic                  wr_pend_q;
  logic [`CSA_AW-1:0]    addr_q;
  logic [`CSA_N-1:0]     opa_q;
  logic [`CSA_N-1:0]     opb_q;
  logic [`CSA_CTRL_W-1:0] ctrl_q;
  logic [`CSA_N-1:0]     cell_ce_q;
  logic [`CSA_N-1:0]     ce_sel_q;
  logic [`CSA_N-1:0]     ld_val_q;
  logic [`CSA_N-1:0]     cell_q;

  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire wr_now  = wr_pend_q;
  wire wr_opa  = wr_now & (addr_q == `CSA_ADDR_OPA);
  wire wr_opb  = wr_now & (addr_q == `CSA_ADDR_OPB);
  wire wr_ctrl = wr_now & (addr_q == `CSA_ADDR_CTRL);
  wire wr_cce  = wr_now & (addr_q == `CSA_ADDR_CELCE);
  wire wr_csel = wr_now & (addr_q == `CSA_ADDR_CESEL);
  wire wr_ldv  = wr_now & (addr_q == `CSA_ADDR_LDVAL);
  wire wr_cmd  = wr_now & (addr_q == `CSA_ADDR_CMD);

  // Clear and load are one-cycle commands shared by every cell.
  wire clr_now = wr_cmd & i_hwdata[`CSA_B_CLR];
  wire ld_now  = wr_cmd & i_hwdata[`CSA_B_LD];

  // Address phase capture; zero wait states, so hreadyout stays high.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_pend_q <= 1'b0;
      addr_q    <= '0;
    end else begin
      wr_pend_q <= addr_ok & i_hwrite;
      if (addr_ok) begin
        addr_q <= i_haddr[`CSA_AW-1:0];
      end
    end
  end

  // Software registers; unmapped writes are dropped.
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      opa_q     <= `CSA_CELL_RST;
      opb_q     <= `CSA_CELL_RST;
      ctrl_q    <= `CSA_CTRL_RST;
      cell_ce_q <= `CSA_CELCE_RST;
      ce_sel_q  <= `CSA_CELL_RST;
      ld_val_q  <= `CSA_CELL_RST;
    end else begin
      if (wr_opa)  opa_q     <= i_hwdata[`CSA_N-1:0];
      if (wr_opb)  opb_q     <= i_hwdata[`CSA_N-1:0];
      if (wr_ctrl) ctrl_q    <= i_hwdata[`CSA_CTRL_W-1:0];
      if (wr_cce)  cell_ce_q <= i_hwdata[`CSA_N-1:0];
      if (wr_csel) ce_sel_q  <= i_hwdata[`CSA_N-1:0];
      if (wr_ldv)  ld_val_q  <= i_hwdata[`CSA_N-1:0];
    end
  end

  // ========================================================================
  // Operand and carry steering
  // ========================================================================
  csa_mode_e mode;
  assign mode = csa_mode_e'(ctrl_q[`CSA_B_MODE_HI:`CSA_B_MODE_LO]);

  wire is_add = (mode == CSA_MODE_ADD);
  wire is_cnt = (mode == CSA_MODE_CNT);
  wire is_nrm = (mode == CSA_MODE_NORM);
  // Count controls are ordinary data bits, not dedicated lines.
  wire cnt_up = ctrl_q[`CSA_B_UP];
  wire cnt_en = ctrl_q[`CSA_B_CNTEN];
  wire ce0    = ctrl_q[`CSA_B_CE0];
  wire ce1    = ctrl_q[`CSA_B_CE1];

  // A counter adds one, or adds all ones to step down.
  wire [`CSA_N-1:0] op_a = is_add ? opa_q : cell_q;
  wire [`CSA_N-1:0] op_b = is_cnt ? {`CSA_N{~cnt_up}} : opb_q;
  wire clu_cin = is_cnt ? cnt_up : ctrl_q[`CSA_B_CIN];

  // ========================================================================
  // Cells and the dual carry select chain
  // ========================================================================
  logic [`CSA_N:0]   zero_chain_carry_in;
  logic [`CSA_N:0]   one_chain_carry_in;
  logic [`CSA_N-1:0] sum_comb;
  logic [`CSA_N-1:0] cell_en;

  assign zero_chain_carry_in[0] = 1'b0;
  assign one_chain_carry_in[0]  = 1'b1;

  for (genvar i = 0; i < `CSA_N; i++) begin : g_cell
    // Four two-input tables per cell.
    wire first_operand  = op_a[i];
    wire second_operand = op_b[i];
    wire sum_if1  = ~(first_operand ^ second_operand);
    wire sum_if0  = first_operand ^ second_operand;
    wire gen_if1  = first_operand | second_operand;
    wire gen_if0  = first_operand & second_operand;
    // Each chain's own carry picks that chain's outgoing carry.
    wire zero_chain_carry_out = zero_chain_carry_in[i] ? gen_if1 : gen_if0;
    wire one_chain_carry_out  = one_chain_carry_in[i] ? gen_if1 : gen_if0;
    assign zero_chain_carry_in[i+1] = zero_chain_carry_out;
    assign one_chain_carry_in[i+1]  = one_chain_carry_out;
    // The cluster carry picks a chain; its level picks the sum.
    wire sel_carry = clu_cin ? one_chain_carry_in[i] : zero_chain_carry_in[i];
    assign sum_comb[i] = sel_carry ? sum_if1 : sum_if0;
    // Own enable gated by one of two cluster enables.
    assign cell_en[i] = cell_ce_q[i] & (ce_sel_q[i] ? ce1 : ce0);
    wire step = cell_en[i] & (~is_cnt | cnt_en);
    wire nxt  = is_nrm ? opa_q[i] : sum_comb[i];

    // Clear beats load beats the enabled step.
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
      if (!rst_n_q) begin
        cell_q[i] <= 1'b0;
      end else if (clr_now) begin
        cell_q[i] <= 1'b0;
      end else if (ld_now) begin
        cell_q[i] <= ld_val_q[i];
      end else if (step) begin
        cell_q[i] <= nxt;
      end
    end
  end

  wire zero_cout = zero_chain_carry_in[`CSA_N];
  wire one_cout  = one_chain_carry_in[`CSA_N];
  wire sel_cout  = clu_cin ? one_cout : zero_cout;
  // A packed register is only offered when the carry input is unused.
  wire pack_avail = ctrl_q[`CSA_B_PACK] & is_nrm & ~ctrl_q[`CSA_B_CIN];

  // ========================================================================
  // Read mux
  // ========================================================================
  // Combinational and registered copies are both readable at once.
  wire [`CSA_DW-1:0] stat_w = {{`CSA_STAT_PAD{1'b0}}, pack_avail, sel_cout,
                               one_cout, zero_cout, sum_comb};
  wire [`CSA_DW-1:0] pad_n  = '0;
  wire [`CSA_DW-1:0] pad_c  = '0;

  always_comb begin
    o_hrdata = '0;
    case (addr_q)
      `CSA_ADDR_OPA:   o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], opa_q};
      `CSA_ADDR_OPB:   o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], opb_q};
      `CSA_ADDR_CTRL:  o_hrdata = {pad_c[`CSA_DW-1:`CSA_CTRL_W], ctrl_q};
      `CSA_ADDR_CELCE: o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], cell_ce_q};
      `CSA_ADDR_CESEL: o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], ce_sel_q};
      `CSA_ADDR_LDVAL: o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], ld_val_q};
      `CSA_ADDR_STAT:  o_hrdata = stat_w;
      `CSA_ADDR_QOUT:  o_hrdata = {pad_n[`CSA_DW-1:`CSA_N], cell_q};
      default:         o_hrdata = '0;
    endcase
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_q);

  wire [`CSA_N:0] ref_sum = {1'b0, opa_q} + {1'b0, opb_q} + {{`CSA_N{1'b0}}, ctrl_q[`CSA_B_CIN]};
  wire quiet   = ~clr_now & ~ld_now;
  wire all_en  = &cell_en;

  // Plain integer sums of whatever the tables see, for both assumed carries.
  // They come from a word adder, not from the gate chain, so a wrong table or
  // a wrong chain select shows up as a difference.
  wire [`CSA_N:0] ref_c0  = {1'b0, op_a} + {1'b0, op_b};
  wire [`CSA_N:0] ref_c1  = {1'b0, op_a} + {1'b0, op_b} + {{`CSA_N{1'b0}}, 1'b1};
  wire [`CSA_N:0] ref_sel = clu_cin ? ref_c1 : ref_c0;
  wire [`CSA_N-1:0] en_ref = cell_ce_q & ((ce_sel_q & {`CSA_N{ce1}}) | (~ce_sel_q & {`CSA_N{ce0}}));

  chk_adder_sum: assert property (is_add |-> sum_comb == ref_sum[`CSA_N-1:0])
    else $error("adder sum differs from operands plus carry");
  chk_adder_cout: assert property (is_add |-> sel_cout == ref_sum[`CSA_N])
    else $error("selected carry out wrong");
  chk_clear_wins: assert property (clr_now |=> cell_q == `CSA_CELL_RST)
    else $error("clear did not zero all cells");
  chk_load_value: assert property (ld_now && !clr_now |=> cell_q == $past(ld_val_q))
    else $error("load did not take load value");
  chk_count_up: assert property (is_cnt && cnt_up && cnt_en && all_en && quiet
                                 |=> cell_q == $past(cell_q) + 10'h001)
    else $error("counter did not step up");
  chk_count_down: assert property (is_cnt && !cnt_up && cnt_en && all_en && quiet
                                   |=> cell_q == $past(cell_q) - 10'h001)
    else $error("counter did not step down");
  chk_count_hold: assert property (is_cnt && !cnt_en && quiet ##0 $stable(ctrl_q)
                                   |=> $stable(cell_q))
    else $error("counter moved without count enable");
  chk_cell_gate: assert property (quiet && cell_en == '0 |=> $stable(cell_q))
    else $error("cell changed with clock enable off");
  chk_pack_block: assert property (ctrl_q[`CSA_B_CIN] |-> !pack_avail)
    else $error("packing offered while carry in used");
  chk_acc_step: assert property (mode == CSA_MODE_ACC && all_en && quiet
                                 |=> cell_q == $past(cell_q) + $past(opb_q) +
                                     {9'h000, $past(ctrl_q[`CSA_B_CIN])})
    else $error("accumulator did not add");

  // Each chain must carry exactly as a word adder with its assumed carry-in.
  chk_zero_chain: assert property (zero_cout == ref_c0[`CSA_N])
    else $error("zero chain final carry wrong");
  chk_one_chain: assert property (one_cout == ref_c1[`CSA_N])
    else $error("one chain final carry wrong");

  // The unregistered sum follows the chain that the cluster carry picks.
  chk_sum_select: assert property (sum_comb == ref_sel[`CSA_N-1:0])
    else $error("unregistered sum not from selected chain");
  chk_cout_select: assert property (sel_cout == ref_sel[`CSA_N])
    else $error("selected final carry wrong");

  // Each cell's enable is its own bit and one of the two cluster enables.
  chk_enable_map: assert property (cell_en == en_ref)
    else $error("cell enable map wrong");

  // Normal mode registers the first operand when fully enabled.
  chk_normal_take: assert property (is_nrm && all_en && quiet |=> cell_q == $past(opa_q))
    else $error("normal mode did not register operand");

  // Packing is never offered outside normal mode.
  chk_pack_mode: assert property (pack_avail |-> is_nrm)
    else $error("packing offered outside normal mode");

  // Both copies of the cell output are readable while the data phase stands.
  chk_qout_read: assert property (addr_q == `CSA_ADDR_QOUT |-> o_hrdata[`CSA_N-1:0] == cell_q)
    else $error("registered output read wrong");
  chk_stat_read: assert property (addr_q == `CSA_ADDR_STAT |-> o_hrdata[`CSA_N-1:0] == ref_sel[`CSA_N-1:0])
    else $error("unregistered output read wrong");

  // The slave never stalls and never reports an error.
  chk_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready and okay");

  // An accepted write address is followed by its data phase write strobe.
  chk_write_pend: assert property (addr_ok && i_hwrite |=> wr_pend_q)
    else $error("write address phase lost");
  chk_ctrl_write: assert property (wr_ctrl |=> ctrl_q == $past(i_hwdata[`CSA_CTRL_W-1:0]))
    else $error("control write did not land");

  // Clear acts on every cell even with all enables off.
  chk_clear_gated: assert property (clr_now && cell_en == '0 |=> cell_q == `CSA_CELL_RST)
    else $error("clear blocked by enables");

  cov_add_carry: cover property (is_add && sel_cout);
  cov_count_wrap: cover property (is_cnt && cnt_up && cnt_en && all_en && cell_q == 10'h3ff);
  cov_load_then_count: cover property (ld_now ##1 (is_cnt && cnt_en && all_en));
  cov_clear_and_load: cover property (clr_now && ld_now);
  cov_count_down_wrap: cover property (is_cnt && !cnt_up && cnt_en && all_en && cell_q == `CSA_CELL_RST);

endmodule // csa_cluster

// ==== csa_ahb_host.sv ====
`timescale 1ns/1ps

// ====================================================
// Bus master standing in for the software side.
// ====================================================
module csa_ahb_host (
  input  wire logic        i_clk,
  input  wire logic        i_ready,
  input  wire logic [31:0] i_rdata,
  output logic             o_sel,
  output logic [31:0]      o_addr,
  output logic [1:0]       o_trans,
  output logic             o_write,
  output logic [31:0]      o_wdata
);
  // Idle bus from time zero, so nothing is taken during reset.
  initial begin
    o_sel = 1'b0;
    o_addr = 32'h0;
    o_trans = 2'h0;
    o_write = 1'b0;
    o_wdata = 32'h0;
  end

  // One single word transfer; each phase is held until ready is seen high.
  // Read data are taken at the edge that ends the data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    o_sel <= 1'b1;
    o_addr <= {24'h0, a};
    o_trans <= 2'h2;
    o_write <= w;
    @(posedge i_clk);
    while (i_ready !== 1'b1) @(posedge i_clk);
    o_trans <= 2'h0;
    o_wdata <= wd;
    @(posedge i_clk);
    while (i_ready !== 1'b1) @(posedge i_clk);
    rd = i_rdata;
  endtask
endmodule // csa_ahb_host

// ==== csa_cluster_tb.sv ====
`timescale 1ns/1ps
`include "csa_params.svh"

// ====================================================
// Bench: integer model of the cluster checked over the bus.
// ====================================================
module csa_cluster_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sel, wr_en, rdy, resp;
  logic [31:0] addr, wdata, rdata;
  logic [1:0]  trans;
  int          seed = 18;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;

  csa_cluster u_csa_cluster (.i_clk_sys(clk), .i_rst_b(rst_b), .i_hsel(sel), .i_haddr(addr),
    .i_htrans(trans), .i_hwrite(wr_en), .i_hsize(3'h2), .i_hready(rdy), .i_hwdata(wdata),
    .o_hrdata(rdata), .o_hreadyout(rdy), .o_hresp(resp));
  csa_ahb_host u_csa_ahb_host (.i_clk(clk), .i_ready(rdy), .i_rdata(rdata), .o_sel(sel),
    .o_addr(addr), .o_trans(trans), .o_write(wr_en), .o_wdata(wdata));

  // Clock at 40 MHz; the cycle counter cuts a hang short.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    logic [31:0] r;
    u_csa_ahb_host.xfer(1'b1, a, 32'(d), r);
  endtask

  // Read and compare; the response code is always expected to be OKAY.
  task automatic rc(input logic [7:0] a, input int e, input string n);
    logic [31:0] r;
    u_csa_ahb_host.xfer(1'b0, a, 32'($random(seed)), r);
    chk(n, 32'(e), r);
    chk("hresp", 32'h0, {31'h0, resp});
  endtask

  // Main sequence; expectations come from integer arithmetic only.
  initial begin
    int a, b, c, m1, m2, s, up, l;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 10; i++) rc(8'(4 * i), (i == 3) ? 'h3ff : 0, "reset value");
    wr(8'h24, $random(seed));
    rc(8'h24, 0, "unmapped");
    // Adder with either cluster enable, random cell masks.
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 'h3ff : $random(seed) & 'h3ff;
      b = (k == 0) ? 0 : $random(seed) & 'h3ff;
      c = (k == 0) ? 1 : $random(seed) & 1;
      m1 = $random(seed) & 'h3ff;
      m2 = $random(seed) & 'h3ff;
      up = $random(seed) & 1;
      wr(`CSA_ADDR_CTRL, 0);
      wr(`CSA_ADDR_CMD, 1);
      wr(`CSA_ADDR_OPA, a);
      wr(`CSA_ADDR_OPB, b);
      wr(`CSA_ADDR_CELCE, m1);
      wr(`CSA_ADDR_CESEL, m2);
      wr(`CSA_ADDR_CTRL, c | (up ? 'h40 : 'h20));
      s = a + b + c;
      rc(`CSA_ADDR_OPB, b, "opb");
      rc(`CSA_ADDR_STAT, (s & 'h3ff) | ((a + b) >> 10) << 10 | ((a + b + 1) >> 10) << 11 | (s >> 10) << 12, "status");
      rc(`CSA_ADDR_QOUT, s & m1 & (up ? m2 : ~m2) & 'h3ff, "qout");
    end
    // Counter across wrap boundaries: two steps, then counter enable off.
    for (int k = 0; k < 4; k++) begin
      up = (k % 2 == 0);
      l = (k == 0) ? 'h3ff : (k == 1) ? 0 : $random(seed) & 'h3ff;
      wr(`CSA_ADDR_CTRL, 0);
      wr(`CSA_ADDR_CELCE, 'h3ff);
      wr(`CSA_ADDR_CESEL, 0);
      wr(`CSA_ADDR_LDVAL, l);
      wr(`CSA_ADDR_CMD, 2);
      rc(`CSA_ADDR_QOUT, l, "load");
      wr(`CSA_ADDR_CTRL, up ? 'h3c : 'h34);
      wr(`CSA_ADDR_CTRL, up ? 'h2c : 'h24);
      repeat (3) @(posedge clk);
      rc(`CSA_ADDR_QOUT, (l + (up ? 2 : 1022)) % 1024, "count");
      wr(`CSA_ADDR_CMD, 3);
      rc(`CSA_ADDR_QOUT, 0, "clear over load");
    end
    // Accumulator: exactly two enabled edges.
    for (int k = 0; k < 3; k++) begin
      b = $random(seed) & 'h3ff;
      c = k & 1;
      l = $random(seed) & 'h3ff;
      wr(`CSA_ADDR_CTRL, 0);
      wr(`CSA_ADDR_OPB, b);
      wr(`CSA_ADDR_LDVAL, l);
      wr(`CSA_ADDR_CMD, 2);
      wr(`CSA_ADDR_CTRL, 'h22 | c);
      wr(`CSA_ADDR_CTRL, 'h02 | c);
      rc(`CSA_ADDR_QOUT, (l + 2 * (b + c)) % 1024, "accumulate");
    end
    // Normal mode; packing is lost once the carry-in is used.
    for (int k = 0; k < 2; k++) begin
      logic [31:0] v;
      a = $random(seed) & 'h3ff;
      wr(`CSA_ADDR_CTRL, 0);
      wr(`CSA_ADDR_OPA, a);
      wr(`CSA_ADDR_CTRL, 'ha6 | k);
      rc(`CSA_ADDR_QOUT, a, "normal");
      u_csa_ahb_host.xfer(1'b0, `CSA_ADDR_STAT, 32'h0, v);
      chk("pack", 32'(k == 0), {31'h0, v[13]});
    end
    stop_test();
  end
endmodule // csa_cluster_tb
